// ==== rtl/dram_timing_consts.vh ====
`ifndef DRAM_TIMING_CONSTS_VH
`define DRAM_TIMING_CONSTS_VH

// ==========================================================================
// Register map, byte addresses.
`define MTC_ADDR        4'h0
`define STATUS_ADDR     4'h4

// ==========================================================================
// Control register fields and reset value.
`define MTC_RESET       32'h00000000
`define MTC_WMASK       32'hF8BBFFFF
`define MTC_ROW_HOLD    31
`define MTC_TRC_LSB     27
`define MTC_CAS_NEGATE_PERIOD        23
`define MTC_TPC_LSB     19
`define MTC_RCD_LSB     16
`define MTC_WRITE_TO_PRECHARGE_DELAY_LSB    13
`define MTC_REFRESH_ASSERT_PERIOD_LSB    10
`define MTC_BURST       9
`define MTC_SZ_LSB      7
`define MTC_MULTIPLEX_EXTENSION      6
`define MTC_AMX_LSB     3
`define MTC_EDO         0

// ==========================================================================
// Width codes of the memory size field.
`define SZ_64           2'h0
`define SZ_BAD          2'h1
`define SZ_16           2'h2
`define SZ_32           2'h3

// ==========================================================================
// Timing offsets in bus clock cycles, added to the programmed codes, and the column bit base.
`define REFRESH_STEP    6'h03
`define ASYNC_PRE_ADD   6'h00
`define SYNC_PRE_ADD    6'h01
`define ASYNC_RCD_ADD   6'h02
`define SYNC_RCD_ADD    6'h01
`define WRITE_TO_PRECHARGE_DELAY_ADD        6'h01
`define CAS_NEG_ADD     6'h01
`define CBR_HOLD_ADD    6'h02
`define SYNC_REF_ADD    6'h04
`define COLUMN_BASE     4'h8

// ==========================================================================
// Bus responses.
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ==== rtl/dram_sdram_timing_config.v ====
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ns
`include "dram_timing_consts.vh"

module dram_sdram_timing_config (
  // Clock and resets.
  input  wire        clk,
  input  wire        rstn,
  input  wire        manual_rstn,
  // AXI4-Lite slave.
  input  wire [3:0]  awaddr,
  input  wire        awvalid,
  output reg         awready,
  input  wire [31:0] wdata,
  input  wire [3:0]  wstrb,
  input  wire        wvalid,
  output reg         wready,
  output reg  [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready,
  input  wire [3:0]  araddr,
  input  wire        arvalid,
  output reg         arready,
  output reg  [31:0] rdata,
  output reg  [1:0]  rresp,
  output reg         rvalid,
  input  wire        rready,
  // Memory sequencer inputs: mode and transfer levels, and events as one-cycle pulses.
  input  wire        sdram_mode,
  input  wire        ev_activate,
  input  wire        ev_ras_negate,
  input  wire        ev_precharge,
  input  wire        ev_write_done,
  input  wire        ev_refresh,
  input  wire        ev_cas_negate,
  input  wire [1:0]  xfer_size,
  input  wire        xfer_line,
  // Timing permissions.
  output reg         act_ok,
  output reg         cas_ok,
  output reg         pre_ok,
  output reg         refresh_ras_hold,
  // Decoded configuration.
  output reg  [1:0]  bus_width,
  output reg  [3:0]  column_bits,
  output reg  [3:0]  row_shift,
  output reg         burst_xfer,
  output reg         fast_page,
  output reg         edo_xfer,
  output reg         ras_down,
  output reg         config_error
);

  // ========================================================================
  // Control register and field decode.
  reg  [31:0] memory_timing_control;
  wire [2:0]  refresh_end_precharge   = memory_timing_control[`MTC_TRC_LSB +: 3];
  wire        cas_negate_period       = memory_timing_control[`MTC_CAS_NEGATE_PERIOD];
  wire [2:0]  precharge_period        = memory_timing_control[`MTC_TPC_LSB +: 3];
  wire [1:0]  row_to_column_delay     = memory_timing_control[`MTC_RCD_LSB +: 2];
  wire [2:0]  write_to_precharge_delay = memory_timing_control[`MTC_WRITE_TO_PRECHARGE_DELAY_LSB +: 3];
  wire [2:0]  refresh_assert_period   = memory_timing_control[`MTC_REFRESH_ASSERT_PERIOD_LSB +: 3];
  wire        burst_select            = memory_timing_control[`MTC_BURST];
  wire [1:0]  memory_size_field       = memory_timing_control[`MTC_SZ_LSB +: 2];
  wire        multiplex_extension     = memory_timing_control[`MTC_MULTIPLEX_EXTENSION];
  wire [2:0]  address_multiplex_code  = memory_timing_control[`MTC_AMX_LSB +: 3];
  wire        extended_out_select     = memory_timing_control[`MTC_EDO];
  wire        row_hold_select         = memory_timing_control[`MTC_ROW_HOLD];

  // ========================================================================
  // Cycle counts derived from the fields.
  wire [5:0] trc_cyc  = {2'h0, refresh_end_precharge, 1'b0} +
                        {3'h0, refresh_end_precharge};
  wire [5:0] tpc_cyc  = {3'h0, precharge_period} +
                        (sdram_mode ? `SYNC_PRE_ADD : `ASYNC_PRE_ADD);
  wire [5:0] rcd_cyc  = {4'h0, row_to_column_delay} +
                        (sdram_mode ? `SYNC_RCD_ADD : `ASYNC_RCD_ADD);
  wire [5:0] write_to_precharge_delay_cyc = {3'h0, write_to_precharge_delay} + `WRITE_TO_PRECHARGE_DELAY_ADD;
  wire [5:0] cas_negate_period_cyc = {5'h00, cas_negate_period} + `CAS_NEG_ADD;
  wire [5:0] hold_cyc = {3'h0, refresh_assert_period} + `CBR_HOLD_ADD;
  wire [5:0] sref_cyc = {3'h0, refresh_assert_period} + `SYNC_REF_ADD + trc_cyc;
  wire [5:0] aref_cyc = hold_cyc + trc_cyc;
  wire [5:0] wact_cyc = tpc_cyc + write_to_precharge_delay_cyc;

  // Longer of a running count and a new load, so no hold is ever cut short.
  function [5:0] longer;
    input [5:0] a;
    input [5:0] b;
    begin
      longer = (a > b) ? a : b;
    end
  endfunction

  function [5:0] dec;
    input [5:0] a;
    begin
      dec = (a == 6'h00) ? 6'h00 : a - 6'h01;
    end
  endfunction

  // ========================================================================
  // Timing counters. Each count is the number of cycles still blocked.
  reg  [5:0] act_cnt;
  reg  [5:0] cas_cnt;
  reg  [5:0] pre_cnt;
  reg  [5:0] hold_cnt;
  reg  [5:0] next_act_cnt;
  reg  [5:0] next_cas_cnt;
  reg  [5:0] next_pre_cnt;
  reg  [5:0] next_hold_cnt;

  always @* begin
    next_act_cnt  = dec(act_cnt);
    next_cas_cnt  = dec(cas_cnt);
    next_pre_cnt  = dec(pre_cnt);
    next_hold_cnt = dec(hold_cnt);
    if (!sdram_mode && ev_ras_negate) begin
      next_act_cnt = longer(next_act_cnt, tpc_cyc);
    end
    if (sdram_mode && ev_precharge) begin
      next_act_cnt = longer(next_act_cnt, tpc_cyc);
    end
    if (ev_activate) begin
      next_cas_cnt = longer(next_cas_cnt, rcd_cyc);
    end
    if (!sdram_mode && ev_cas_negate) begin
      next_cas_cnt = longer(next_cas_cnt, cas_negate_period_cyc);
    end
    if (sdram_mode && ev_write_done) begin
      next_pre_cnt = longer(next_pre_cnt, write_to_precharge_delay_cyc);
      if (!row_hold_select) begin
        next_act_cnt = longer(next_act_cnt, wact_cyc);
      end
    end
    if (ev_refresh) begin
      if (sdram_mode) begin
        next_act_cnt = longer(next_act_cnt, sref_cyc);
      end else begin
        next_hold_cnt = longer(next_hold_cnt, hold_cyc);
        next_act_cnt  = longer(next_act_cnt, aref_cyc);
      end
    end
  end

  // ========================================================================
  // Manual reset input, three stages. It comes from outside this clock, so
  // a level counts only once the last two stages agree; a one-sample glitch
  // never clears the timers.
  reg        mrst_s1;
  reg        mrst_s2;
  reg        mrst_s3;
  reg        manual_clear;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      mrst_s1      <= 1'b1;
      mrst_s2      <= 1'b1;
      mrst_s3      <= 1'b1;
      manual_clear <= 1'b0;
    end else begin
      mrst_s1 <= manual_rstn;
      mrst_s2 <= mrst_s1;
      mrst_s3 <= mrst_s2;
      if (mrst_s2 == mrst_s3) begin
        manual_clear <= !mrst_s3;
      end
    end
  end

  // Manual reset restarts the sequencer timing but leaves the register alone.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_cnt          <= 6'h00;
      cas_cnt          <= 6'h00;
      pre_cnt          <= 6'h00;
      hold_cnt         <= 6'h00;
      act_ok           <= 1'b1;
      cas_ok           <= 1'b1;
      pre_ok           <= 1'b1;
      refresh_ras_hold <= 1'b0;
    end else if (manual_clear) begin
      act_cnt          <= 6'h00;
      cas_cnt          <= 6'h00;
      pre_cnt          <= 6'h00;
      hold_cnt         <= 6'h00;
      act_ok           <= 1'b1;
      cas_ok           <= 1'b1;
      pre_ok           <= 1'b1;
      refresh_ras_hold <= 1'b0;
    end else begin
      act_cnt          <= next_act_cnt;
      cas_cnt          <= next_cas_cnt;
      pre_cnt          <= next_pre_cnt;
      hold_cnt         <= next_hold_cnt;
      act_ok           <= (next_act_cnt == 6'h00);
      cas_ok           <= (next_cas_cnt == 6'h00);
      pre_ok           <= (next_pre_cnt == 6'h00);
      refresh_ras_hold <= (next_hold_cnt != 6'h00);
    end
  end

  // ========================================================================
  // Configuration decode and setting checks.
  wire wide_xfer   = (xfer_size == 2'h2) || (xfer_size == 2'h3);
  wire is_64       = (xfer_size == 2'h3);
  // Set by a control write that tried to set a reserved bit.
  reg  bad_rsvd;
  wire bad_rasdown = row_hold_select && sdram_mode &&
                     ((precharge_period == 3'h0) || (precharge_period >= 3'h3) ||
                      (row_to_column_delay == 2'h3) || (write_to_precharge_delay >= 3'h2));
  wire bad_sync    = sdram_mode && ((row_to_column_delay == 2'h0) ||
                     (write_to_precharge_delay > 3'h4) || (memory_size_field == `SZ_16));
  wire bad_async   = !sdram_mode && ((!burst_select && extended_out_select) ||
                     multiplex_extension || (row_hold_select && !burst_select));
  wire bad_amx     = !sdram_mode && (address_multiplex_code > 3'h4);
  wire bad_size    = (memory_size_field == `SZ_BAD);
  wire [3:0] col   = `COLUMN_BASE + {1'b0, address_multiplex_code};
  wire [3:0] bshift = (memory_size_field == `SZ_64) ? 4'h3 :
                      (memory_size_field == `SZ_32) ? 4'h2 : 4'h1;

  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bus_width    <= `SZ_64;
      column_bits  <= `COLUMN_BASE;
      row_shift    <= `COLUMN_BASE;
      burst_xfer   <= 1'b0;
      fast_page    <= 1'b0;
      edo_xfer     <= 1'b0;
      ras_down     <= 1'b0;
      config_error <= 1'b0;
    end else begin
      // The bus width is taken from the size field alone.
      bus_width    <= memory_size_field;
      column_bits  <= col;
      row_shift    <= sdram_mode ? col + bshift : col;
      burst_xfer   <= sdram_mode | burst_select;
      fast_page    <= !sdram_mode && burst_select && !extended_out_select &&
                      (xfer_line ||
                       ((memory_size_field == `SZ_16) && wide_xfer) ||
                       ((memory_size_field == `SZ_32) && is_64));
      edo_xfer     <= !sdram_mode && burst_select && extended_out_select;
      ras_down     <= row_hold_select;
      config_error <= bad_rsvd | bad_rasdown | bad_sync | bad_async |
                      bad_amx | bad_size;
    end
  end

  // ========================================================================
  // AXI4-Lite write path. Address and data are taken in either order.
  reg        aw_held;
  reg        w_held;
  reg [3:0]  aw_addr;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  reg [31:0] merged;
  integer    i;

  always @* begin
    merged = memory_timing_control;
    for (i = 0; i < 4; i = i + 1) begin
      if (w_strb[i]) begin
        merged[i*8 +: 8] = w_data[i*8 +: 8];
      end
    end
  end

  // Only power-on reset clears the register; manual reset does not.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      memory_timing_control <= `MTC_RESET;
      awready <= 1'b1;
      wready  <= 1'b1;
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_addr <= 4'h0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      bad_rsvd <= 1'b0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
        awready <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
        wready <= 1'b0;
      end
      if (aw_held && w_held && !bvalid) begin
        aw_held <= 1'b0;
        w_held  <= 1'b0;
        bvalid  <= 1'b1;
        if (aw_addr == `MTC_ADDR) begin
          memory_timing_control <= merged & `MTC_WMASK;
          // Reserved bits are dropped, but a write that sets one is remembered.
          bad_rsvd <= |(merged & ~`MTC_WMASK);
          bresp <= `RESP_OKAY;
        end else if (aw_addr == `STATUS_ADDR) begin
          bresp <= `RESP_OKAY;
        end else begin
          bresp <= `RESP_SLVERR;
        end
      end
      if (bvalid && bready) begin
        bvalid  <= 1'b0;
        awready <= 1'b1;
        wready  <= 1'b1;
      end
    end
  end

  // ========================================================================
  // AXI4-Lite read path.
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      arready <= 1'b1;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= `RESP_OKAY;
    end else begin
      if (arvalid && arready) begin
        arready <= 1'b0;
        rvalid  <= 1'b1;
        rresp   <= `RESP_OKAY;
        case (araddr)
          `MTC_ADDR: begin
            rdata <= memory_timing_control & `MTC_WMASK;
          end
          `STATUS_ADDR: begin
            rdata <= {27'h0000000, config_error, refresh_ras_hold,
                      pre_ok, cas_ok, act_ok};
          end
          default: begin
            rdata <= 32'h00000000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
      if (rvalid && rready) begin
        rvalid  <= 1'b0;
        arready <= 1'b1;
      end
    end
  end

endmodule

// ==== sim/dram_timing_checker_assertions.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Timing permission and read data checks.
module dram_timing_checker (
  // Clock and resets.
  input wire        clk,
  input wire        rstn,
  input wire        manual_rstn,
  // Sequencer side.
  input wire        sdram_mode,
  input wire        ev_activate,
  input wire        ev_precharge,
  input wire        ev_write_done,
  input wire        ev_refresh,
  input wire        ev_cas_negate,
  input wire        act_ok,
  input wire        cas_ok,
  input wire        pre_ok,
  input wire        refresh_ras_hold,
  // Read channel.
  input wire        rvalid,
  input wire [31:0] rdata
);
  // A manual reset clears the timers, so every event check needs it high.
  wire sync_on  = manual_rstn && sdram_mode;
  wire async_on = manual_rstn && !sdram_mode;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  a_sync_pre_act: assert property (sync_on && ev_precharge |=> !act_ok)
    else $error("act_ok high after precharge");
  a_async_cas_gap: assert property (async_on && ev_activate |=> !cas_ok [*2])
    else $error("cas_ok high too soon after RAS");
  a_sync_cas_gap: assert property (sync_on && ev_activate |=> !cas_ok)
    else $error("cas_ok high after bank active");
  a_cas_negate: assert property (async_on && ev_cas_negate |=> !cas_ok)
    else $error("cas_ok high during CAS negation");
  a_write_pre: assert property (sync_on && ev_write_done |=> !pre_ok)
    else $error("pre_ok high after write");
  a_cbr_hold: assert property (async_on && ev_refresh |=> refresh_ras_hold [*2])
    else $error("RAS hold shorter than two cycles");
  a_cbr_act: assert property (async_on && ev_refresh |=> !act_ok [*2])
    else $error("act_ok high during refresh");
  a_sync_ref_gap: assert property (sync_on && ev_refresh |=> !act_ok [*4])
    else $error("act_ok high within four cycles of refresh");
  a_reserved_zero: assert property (rvalid |->
    rdata[26:24] == 3'h0 && !rdata[22] && !rdata[18])
    else $error("reserved bits read nonzero");
endmodule

bind dram_sdram_timing_config dram_timing_checker chk_i (
  .clk(clk), .rstn(rstn), .manual_rstn(manual_rstn), .sdram_mode(sdram_mode),
  .ev_activate(ev_activate), .ev_precharge(ev_precharge), .ev_write_done(ev_write_done),
  .ev_refresh(ev_refresh), .ev_cas_negate(ev_cas_negate), .act_ok(act_ok),
  .cas_ok(cas_ok), .pre_ok(pre_ok), .refresh_ras_hold(refresh_ras_hold),
  .rvalid(rvalid), .rdata(rdata));

// ==== sim/mem_seq_model.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Memory sequencer stand-in: one request becomes one event pulse.
module mem_seq_model (
  // Clock and reset.
  input wire       clk,
  input wire       rstn,
  // Request from the bench.
  input wire       req,
  input wire [2:0] kind,
  // Event pulses, one-hot by kind.
  output reg [5:0] ev
);
  // Pulses last one cycle, so no command is counted twice.
  always @(posedge clk or negedge rstn) begin
    if (!rstn)
      ev <= 6'h00;
    else
      ev <= req ? (6'h01 << kind) : 6'h00;
  end
endmodule

// ==== sim/tb_dram_sdram_timing_config.sv ====
`timescale 1ns/1ns
// ==========================================================================
// Signals.
module tb_dram_sdram_timing_config;
  reg         clk, rstn, manual_rstn, awvalid, wvalid, bready, arvalid, rready;
  reg  [3:0]  awaddr, araddr, wstrb;
  reg  [31:0] wdata, rd_data;
  reg  [1:0]  xfer_size, rd_resp, wr_resp;
  reg  [2:0]  kind;
  reg         sdram_mode, xfer_line, req;
  wire [5:0]  ev;
  wire [1:0]  bresp, rresp, bus_width;
  wire [31:0] rdata;
  wire [3:0]  column_bits, row_shift;
  wire        awready, wready, bvalid, arready, rvalid, act_ok, cas_ok, pre_ok;
  wire        refresh_ras_hold, burst_xfer, fast_page, edo_xfer, ras_down, config_error;
  integer     n_errors, n_tests;

  dram_sdram_timing_config dut (.clk(clk), .rstn(rstn), .manual_rstn(manual_rstn),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .sdram_mode(sdram_mode), .ev_activate(ev[0]),
    .ev_ras_negate(ev[1]), .ev_precharge(ev[2]), .ev_write_done(ev[3]),
    .ev_refresh(ev[4]), .ev_cas_negate(ev[5]), .xfer_size(xfer_size),
    .xfer_line(xfer_line), .act_ok(act_ok), .cas_ok(cas_ok), .pre_ok(pre_ok),
    .refresh_ras_hold(refresh_ras_hold), .bus_width(bus_width),
    .column_bits(column_bits), .row_shift(row_shift), .burst_xfer(burst_xfer),
    .fast_page(fast_page), .edo_xfer(edo_xfer), .ras_down(ras_down),
    .config_error(config_error));
  mem_seq_model seq (.clk(clk), .rstn(rstn), .req(req), .kind(kind), .ev(ev));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // ==========================================================================
  // Checking and closing.
  task chk(input [8*12-1:0] name, input [31:0] seen, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  task end_sim;
    begin
      $display("Checks %0d, mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask

  // ==========================================================================
  // Bus master: valid held until its own ready, readies waited for, never assumed.
  task wr(input [3:0] a, input [31:0] d);
    integer i;
    reg     got;
    begin
      got = 1'b0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      for (i = 0; i < 50 && !got; i = i + 1) begin
        @(posedge clk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
        if (bvalid) got = 1'b1;
        if (bvalid) wr_resp = bresp;
      end
      bready <= 1'b0;
      if (!got) chk("bus wait", 0, 1);
      if (!got) end_sim;
    end
  endtask
  task rd(input [3:0] a);
    integer i;
    reg     got;
    begin
      got = 1'b0;
      @(posedge clk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      for (i = 0; i < 50 && !got; i = i + 1) begin
        @(posedge clk);
        if (arready) arvalid <= 1'b0;
        if (rvalid) got = 1'b1;
        if (rvalid) {rd_resp, rd_data} = {rresp, rdata};
      end
      rready <= 1'b0;
      if (!got) chk("bus wait", 0, 1);
      if (!got) end_sim;
    end
  endtask
  task cfg(input [31:0] d, input m);
    begin
      wr(4'h0, d);
      sdram_mode <= m;
      repeat (3) @(negedge clk);
    end
  endtask

  // ==========================================================================
  // Counts the cycles a permission stays low after one event of kind k.
  task meas(input m, input [2:0] k, input [1:0] s, input [31:0] exp);
    integer   i, n;
    reg [3:0] p;
    begin
      n = 0;
      // Let every earlier hold run out first; the longest load is 32 cycles.
      repeat (34) @(posedge clk);
      {sdram_mode, kind, req} <= {m, k, 1'b1};
      @(posedge clk);
      req <= 1'b0;
      for (i = 0; i < 40; i = i + 1) begin
        @(negedge clk);
        p = {~refresh_ras_hold, pre_ok, cas_ok, act_ok};
        if (!p[s]) n = n + 1;
        else if (n > 0) i = 40;
      end
      chk("low cycles", n, exp);
    end
  endtask

  initial begin
    {n_errors, n_tests} = 0;
    {rstn, awvalid, wvalid, bready, arvalid, rready, req, sdram_mode, xfer_line} = 9'h000;
    {awaddr, araddr, wdata, xfer_size, kind} = 45'h0;
    manual_rstn = 1'b1;
    wstrb = 4'hF;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    // Register map, masks and the unmapped place.
    rd(4'h0);
    chk("ctl reset", rd_data, 32'h00000000);
    wr(4'h0, 32'hFFFFFFFF);
    rd(4'h0);
    chk("ctl mask", rd_data, 32'hF8BBFFFF);
    chk("ok resps", {wr_resp, rd_resp}, 32'h0);
    chk("ras_down", ras_down, 32'h1);
    wr(4'h0, 32'h04440000);
    rd(4'h0);
    chk("rsvd read", rd_data, 32'h00000000);
    chk("cfg rsvd", config_error, 32'h1);
    rd(4'h8);
    chk("unmapped rsp", rd_resp, 32'h2);
    chk("unmapped", rd_data, 32'h0);
    wr(4'hC, 32'h00000001);
    chk("unmapped wr", wr_resp, 32'h2);
    // Decoded geometry and transfer modes.
    xfer_size <= 2'h2;
    cfg(32'h00000320, 1'b0);
    chk("bus_width", bus_width, 32'h2);
    chk("column_bits", column_bits, 32'hC);
    chk("fast_page", fast_page, 32'h1);
    chk("row async", row_shift, 32'hC);
    chk("cfg ok", config_error, 32'h0);
    cfg(32'h00000320, 1'b1);
    chk("cfg 16 sync", config_error, 32'h1);
    cfg(32'h00000180, 1'b1);
    chk("burst sync", burst_xfer, 32'h1);
    chk("row sync", row_shift, 32'hA);
    chk("bus_width", bus_width, 32'h3);
    cfg(32'h00000001, 1'b0);
    chk("cfg edo", config_error, 32'h1);
    cfg(32'h00000201, 1'b0);
    chk("edo_xfer", edo_xfer, 32'h1);
    cfg(32'h00000040, 1'b0);
    chk("cfg multiplex_extension", config_error, 32'h1);
    // Manual reset keeps the control register; status shows free permissions.
    wr(4'h0, 32'h08914400);
    @(posedge clk);
    manual_rstn <= 1'b0;
    repeat (2) @(posedge clk);
    manual_rstn <= 1'b1;
    rd(4'h0);
    chk("ctl kept", rd_data, 32'h08914400);
    rd(4'h4);
    chk("status", rd_data, 32'h00000007);
    // Timing: precharge 2, delay code 1, write delay 2, hold 1, refresh end 1.
    meas(1'b0, 3'h1, 2'h0, 2);
    meas(1'b0, 3'h0, 2'h1, 3);
    meas(1'b0, 3'h5, 2'h1, 2);
    meas(1'b0, 3'h4, 2'h3, 3);
    meas(1'b0, 3'h4, 2'h0, 6);
    meas(1'b0, 3'h3, 2'h2, 0);
    meas(1'b1, 3'h2, 2'h0, 3);
    meas(1'b1, 3'h0, 2'h1, 2);
    meas(1'b1, 3'h3, 2'h2, 3);
    meas(1'b1, 3'h3, 2'h0, 6);
    meas(1'b1, 3'h4, 2'h0, 8);
    // In RAS down mode a write no longer holds off the next bank active.
    wr(4'h0, 32'h88914400);
    meas(1'b1, 3'h3, 2'h0, 0);
    chk("cfg rasdown", config_error, 32'h1);
    end_sim;
  end
endmodule
